// ### rtl/cei_pkg.sv
/*
 cei_pkg: register map, field positions and reset values of the comparator
 event interrupt block. Assumes a 32-bit APB slave with word-aligned registers.
*/
package cei_pkg;
	localparam int NUM_CMP = 2;
	// byte offsets of the register words
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_FLAG = 8'h0C;
	localparam logic [7:0] OFF_ENA = 8'h10;
	localparam logic [7:0] OFF_ICTL = 8'h14;
	// comparator_control fields
	localparam int EVSEL_LO = 3;
	localparam int EVSEL_HI = 4;
	localparam int INV_BIT = 5;
	// peripheral_flag_reg / peripheral_enable_reg lowest comparator bit
	localparam int FLAG_LSB = 5;
	// interrupt_control_reg bits
	localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
	localparam int GIE_BIT = 7;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		CEI_EV_NONE = 2'b00,
		CEI_EV_RISE = 2'b01,
		CEI_EV_FALL = 2'b10,
		CEI_EV_ANY = 2'b11
	} cei_evsel_t;
	typedef struct packed {
		logic inv;
		cei_evsel_t evsel;
	} cei_cfg_t;
endpackage

// ### rtl/cei_edge.sv
/*
 cei_edge: one comparator channel - synchroniser, optional inversion and
 event detection. Assumes cmp_raw is asynchronous to pclk.
*/
`timescale 1ns/1ps
module cei_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic cmp_raw,
	input wire cei_pkg::cei_cfg_t cfg,
	output logic cmp_out,
	output logic event_hit
);
	logic sync1_q, sync2_q, prev_q;
	wire logic rise, fall;

	// two-stage synchroniser, then a history bit for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (ce) begin
			sync1_q <= cmp_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// inversion applies to both the reported level and the detection
	assign cmp_out = sync2_q ^ cfg.inv;
	// prev gets the same inversion; xor with inv cancels out for edges
	assign rise = ce && (cmp_out && !(prev_q ^ cfg.inv));
	assign fall = ce && (!cmp_out && (prev_q ^ cfg.inv));
	assign event_hit = (cfg.evsel == cei_pkg::CEI_EV_RISE && rise)
		|| (cfg.evsel == cei_pkg::CEI_EV_FALL && fall)
		|| (cfg.evsel == cei_pkg::CEI_EV_ANY && (rise || fall));
endmodule

// ### rtl/cei_top.sv
/*
 cei_top: comparator event interrupt controller with an APB register port.
 Assumes comparator outputs arrive asynchronously; one system clock domain.
*/
// The register addresses and the APB register port were left to the implementer.
// Behaviour
// - two-bit event select at control bits 4:3 picks the triggering transitions
// - control bit 5 inverts the comparator output before detection and reporting
// - select 01 flags rising edges only, 10 falling edges only
// - select 11 flags every change in either direction
// - select 00 never flags, whatever the inversion
// - a flag stays set until software writes it to zero
// - software writing one to a flag sets it like a hardware event
// - comparator flags sit at bits 6 and 5 of the flag register
// - request needs channel enable, peripheral enable bit 6, global enable bit 7
// - flags still set while any enable is clear
`timescale 1ns/1ps
module cei_top #(
	parameter int NCMP = cei_pkg::NUM_CMP
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCMP-1:0] cmp_raw,
	output logic [NCMP-1:0] comparator_output,
	output logic irq
);
	logic [5:0] ctrl_q [NCMP];
	logic [NCMP-1:0] flag_q, flag_d, ena_q;
	logic peripheral_irq_enable_q, gie_q;
	logic [31:0] rdata_q;
	logic [NCMP-1:0] hit;
	cei_pkg::cei_cfg_t cfg [NCMP];

	// per-channel edge detectors
	for (genvar i = 0; i < NCMP; i++) begin : g_ch
		assign cfg[i].inv = ctrl_q[i][cei_pkg::INV_BIT];
		assign cfg[i].evsel = cei_pkg::cei_evsel_t'(ctrl_q[i][cei_pkg::EVSEL_HI:cei_pkg::EVSEL_LO]);
		cei_edge u_edge (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.cmp_raw(cmp_raw[i]),
			.cfg(cfg[i]),
			.cmp_out(comparator_output[i]),
			.event_hit(hit[i])
		);
	end

	// apb decode: zero wait states, access phase commits
	wire logic acc = psel && penable && ce;
	wire logic wr = acc && pwrite;
	wire logic rd = acc && !pwrite;
	wire logic a_ctrl0 = paddr == cei_pkg::OFF_CTRL0;
	wire logic a_ctrl1 = paddr == cei_pkg::OFF_CTRL1;
	wire logic a_stat = paddr == cei_pkg::OFF_STAT;
	wire logic a_flag = paddr == cei_pkg::OFF_FLAG;
	wire logic a_ena = paddr == cei_pkg::OFF_ENA;
	wire logic a_ictl = paddr == cei_pkg::OFF_ICTL;
	wire logic mapped = a_ctrl0 | a_ctrl1 | a_stat | a_flag | a_ena | a_ictl;
	wire logic [NCMP-1:0] wflag = pwdata[cei_pkg::FLAG_LSB +: NCMP];

	// flag and enable words share one layout, so both reads place their
	// bits through the same helper; a change of FLAG_LSB moves both at once
	function automatic logic [31:0] place_field(input logic [NCMP-1:0] f);
		place_field = 32'(f) << cei_pkg::FLAG_LSB;
	endfunction

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_q;

	// hardware set wins over a software zero in the same cycle
	always_comb begin
		flag_d = flag_q;
		if (wr && a_flag)
			flag_d = wflag;
		flag_d = flag_d | hit;
	end

	// irq gating: every enable level must be set
	assign irq = gie_q && peripheral_irq_enable_q && |(flag_q & ena_q);

	// read mux; status is the post-inversion output, for software history
	wire logic [31:0] rmux =
		a_ctrl0 ? {26'h0, ctrl_q[0]} :
		a_ctrl1 ? {26'h0, ctrl_q[1]} :
		a_stat ? {{(32-NCMP){1'b0}}, comparator_output} :
		a_flag ? place_field(flag_q) :
		a_ena ? place_field(ena_q) :
		a_ictl ? {24'h0, gie_q, peripheral_irq_enable_q, 6'h00} : cei_pkg::RST_WORD;

	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q[0] <= 6'h00;
			ctrl_q[1] <= 6'h00;
			flag_q <= '0;
			ena_q <= '0;
			peripheral_irq_enable_q <= 1'b0;
			gie_q <= 1'b0;
			rdata_q <= cei_pkg::RST_WORD;
		end else if (ce) begin
			flag_q <= flag_d;
			if (wr && a_ctrl0)
				ctrl_q[0] <= pwdata[5:0];
			if (wr && a_ctrl1)
				ctrl_q[1] <= pwdata[5:0];
			if (wr && a_ena)
				ena_q <= wflag;
			if (wr && a_ictl) begin
				peripheral_irq_enable_q <= pwdata[cei_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
				gie_q <= pwdata[cei_pkg::GIE_BIT];
			end
			if (psel && !penable && !pwrite)
				rdata_q <= rmux;
		end
	end

	// assertions
	a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && $past(flag_q[0]) && !$past(wr && a_flag)) |-> flag_q[0])
		else $error("flag cleared without a write");
	a_hit_sets: assert property (@(posedge pclk) disable iff (!presetn)
		hit[0] |=> flag_q[0]) else $error("event did not set flag");
	a_none_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg[0].evsel == cei_pkg::CEI_EV_NONE) |-> !hit[0]) else $error("event in mode 00");
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> (gie_q && peripheral_irq_enable_q)) else $error("irq without global enables");
	a_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_flag && pwdata[cei_pkg::FLAG_LSB]) |=> flag_q[0]) else $error("sw set lost");
	a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[0] && cfg[0].evsel == cei_pkg::CEI_EV_RISE) |-> comparator_output[0])
		else $error("rise mode hit on low");
	a_fall_only: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[0] && cfg[0].evsel == cei_pkg::CEI_EV_FALL) |-> !comparator_output[0])
		else $error("fall mode hit on high");
	a_any_change: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && $past(ce) && cfg[0].evsel == cei_pkg::CEI_EV_ANY && $stable(cfg[0].inv)
		&& comparator_output[0] != $past(comparator_output[0])) |-> hit[0])
		else $error("change missed");

	// second channel: the same guards, so a slip in the channel index of
	// the generate loop or of the flag field cannot hide behind channel 0
	a_flag_sticky1: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && $past(flag_q[1]) && !$past(wr && a_flag)) |-> flag_q[1])
		else $error("flag 1 cleared without a write");

	// an event on channel 1 must land in its own flag bit
	a_hit_sets1: assert property (@(posedge pclk) disable iff (!presetn)
		hit[1] |=> flag_q[1])
		else $error("event did not set flag 1");

	// select 00 keeps channel 1 silent whatever the inversion
	a_none_quiet1: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg[1].evsel == cei_pkg::CEI_EV_NONE) |-> !hit[1])
		else $error("event in mode 00 on channel 1");

	// a software one in the upper flag bit must set channel 1
	a_sw_set1: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_flag && pwdata[cei_pkg::FLAG_LSB + 1]) |=> flag_q[1])
		else $error("sw set lost on channel 1");

	// rising mode on channel 1 only fires with the output high
	a_rise_only1: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[1] && cfg[1].evsel == cei_pkg::CEI_EV_RISE) |-> comparator_output[1])
		else $error("rise mode hit on low, channel 1");

	// falling mode on channel 1 only fires with the output low
	a_fall_only1: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[1] && cfg[1].evsel == cei_pkg::CEI_EV_FALL) |-> !comparator_output[1])
		else $error("fall mode hit on high, channel 1");

	// any-change mode on channel 1 must catch every output step with the inversion steady
	a_any_change1: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && $past(ce) && cfg[1].evsel == cei_pkg::CEI_EV_ANY && $stable(cfg[1].inv)
		&& comparator_output[1] != $past(comparator_output[1])) |-> hit[1])
		else $error("change missed on channel 1");

	// a request needs a pending flag that is also enabled; an enable on
	// its own must never reach the processor
	a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
		irq |-> |(flag_q & ena_q))
		else $error("irq without an enabled flag");

	// all three enable levels set with a pending flag must raise the line
	a_irq_all_set0: assert property (@(posedge pclk) disable iff (!presetn)
		(gie_q && peripheral_irq_enable_q && flag_q[0] && ena_q[0]) |-> irq)
		else $error("irq missing with all enables set, channel 0");

	// same for channel 1, which uses the upper enable bit
	a_irq_all_set1: assert property (@(posedge pclk) disable iff (!presetn)
		(gie_q && peripheral_irq_enable_q && flag_q[1] && ena_q[1]) |-> irq)
		else $error("irq missing with all enables set, channel 1");

	// flipping the inversion bit alone must flip the reported level
	a_inv_flips0: assert property (@(posedge pclk) disable iff (!presetn)
		($changed(cfg[0].inv) && $stable(g_ch[0].u_edge.sync2_q))
		|-> $changed(comparator_output[0]))
		else $error("inversion not applied, channel 0");

	// the same for channel 1
	a_inv_flips1: assert property (@(posedge pclk) disable iff (!presetn)
		($changed(cfg[1].inv) && $stable(g_ch[1].u_edge.sync2_q))
		|-> $changed(comparator_output[1]))
		else $error("inversion not applied, channel 1");

	// no event unless the synchronised level differs from last cycle;
	// this is what keeps an inversion change from faking an edge
	a_edge_needs_step0: assert property (@(posedge pclk) disable iff (!presetn)
		(g_ch[0].u_edge.sync2_q == g_ch[0].u_edge.prev_q) |-> !hit[0])
		else $error("event without a step, channel 0");

	// the same for channel 1
	a_edge_needs_step1: assert property (@(posedge pclk) disable iff (!presetn)
		(g_ch[1].u_edge.sync2_q == g_ch[1].u_edge.prev_q) |-> !hit[1])
		else $error("event without a step, channel 1");

	// with the inversion steady, an event means the reported level moved
	a_hit_moves0: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[0] && $stable(cfg[0].inv)) |-> comparator_output[0] != $past(comparator_output[0]))
		else $error("event with steady output, channel 0");

	// the same for channel 1
	a_hit_moves1: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[1] && $stable(cfg[1].inv)) |-> comparator_output[1] != $past(comparator_output[1]))
		else $error("event with steady output, channel 1");

	// control writes land whole: select and inversion together
	a_ctrl_write0: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_ctrl0) |=> ctrl_q[0] == $past(pwdata[5:0]))
		else $error("control 0 write lost");

	// second control word
	a_ctrl_write1: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_ctrl1) |=> ctrl_q[1] == $past(pwdata[5:0]))
		else $error("control 1 write lost");

	// channel enables take the same bit positions as the flags
	a_ena_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_ena) |=> ena_q == $past(wflag))
		else $error("enable write lost");

	// global and peripheral enables come from their own bits
	a_ictl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_ictl) |=> (gie_q == $past(pwdata[cei_pkg::GIE_BIT])
		&& peripheral_irq_enable_q == $past(pwdata[cei_pkg::PERIPHERAL_IRQ_ENABLE_BIT])))
		else $error("interrupt control write lost");

	// writing zeros with no event pending clears every flag
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && a_flag && wflag == '0 && hit == '0) |=> flag_q == '0)
		else $error("software clear lost");

	// a flag is still caught while the global enable is off
	a_flag_no_gie: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[1] && !gie_q) |=> flag_q[1])
		else $error("flag lost with global enable clear");

	// a frozen cycle must leave the flags untouched; ce low blocks events
	// as well as bus writes, so nothing may sneak in
	a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		$past(!ce) |-> $stable(flag_q))
		else $error("flags moved while frozen");

	// flag read shows the flags in their documented bit positions
	a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && psel && !penable && !pwrite && a_flag)
		|=> prdata[cei_pkg::FLAG_LSB +: NCMP] == $past(flag_q))
		else $error("flag read misplaced");

	// status read returns the reported levels software keeps as history
	a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && psel && !penable && !pwrite && a_stat)
		|=> prdata[NCMP-1:0] == $past(comparator_output))
		else $error("status read wrong");

	// read data holds between read setups, so a slow master still sees it
	a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(ce && psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");

	// zero wait states: the slave never stretches an access
	a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
		pready)
		else $error("pready low");

	// an access to a hole in the map must report an error
	a_err_hole: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !a_ctrl0 && !a_ctrl1 && !a_stat && !a_flag && !a_ena
		&& !a_ictl) |-> pslverr)
		else $error("unmapped access not refused");

	// an access to the status, flag, enable or interrupt control word must not report an error
	a_err_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && (a_flag || a_ena || a_ictl || a_stat)) |-> !pslverr)
		else $error("mapped access refused");
endmodule

// ### bench/cei_top_bench.sv
/* cei_top_bench: self-checking bench for cei_top.
 Assumes the APB map and latencies of cei_pkg; ce is held high. */
`timescale 1ns/1ps
module cei_top_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic [1:0] cmp_raw = 2'b00, comparator_output;
	logic e;
	int error_cnt = 0, comparisons = 0;
	cei_top DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_raw(cmp_raw), .comparator_output(comparator_output), .irq(irq));
	// free-running system clock
	always #5 pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	// entered just after a rising edge; waits for pready, no fixed latency assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) error_cnt++;
		v = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, x, v);
	endtask
	// raw comparator change, then let synchroniser and flag settle
	task automatic raw(input int ch, input logic b);
		cmp_raw[ch] <= b;
		repeat (6) @(posedge pclk);
	endtask
	task automatic t_reset;
		for (int a = 0; a < 24; a += 4) rdc(8'(a), 32'h0, "reset word");
		rdc(8'h18, 32'h0, "unmapped");
		chk("pslverr", 32'h1, 32'(e));
	endtask
	// every select and inversion on both channels, all enables clear
	task automatic t_modes;
		logic inv;
		logic [1:0] ev;
		logic [7:0] c;
		logic xr, xf;
		for (int ch = 0; ch < 2; ch++) for (int k = 0; k < 8; k++) begin
			inv = k[2]; ev = k[1:0]; c = 8'(ch * 4);
			apb(1'b1, c, {26'h0, inv, 2'b00, 3'h0});
			repeat (6) @(posedge pclk);
			rdc(cei_pkg::OFF_STAT, 32'(inv) << ch, "status");
			apb(1'b1, c, {26'h0, inv, ev, 3'h0});
			apb(1'b1, cei_pkg::OFF_FLAG, 32'h0);
			xr = ev == 2'b11 || (ev == 2'b01 && !inv) || (ev == 2'b10 && inv);
			xf = ev == 2'b11 || (ev == 2'b01 && inv) || (ev == 2'b10 && !inv);
			raw(ch, 1'b1);
			rdc(cei_pkg::OFF_FLAG, 32'(xr) << (5 + ch), "flag rise");
			apb(1'b1, cei_pkg::OFF_FLAG, 32'h0);
			raw(ch, 1'b0);
			rdc(cei_pkg::OFF_FLAG, 32'(xf) << (5 + ch), "flag fall");
			apb(1'b1, c, 32'h0);
		end
		apb(1'b1, cei_pkg::OFF_FLAG, 32'h0);
	endtask
	// software set, enable gating and software clear
	task automatic t_irq;
		apb(1'b1, cei_pkg::OFF_FLAG, 32'h40);
		rdc(cei_pkg::OFF_FLAG, 32'h40, "soft flag");
		apb(1'b1, cei_pkg::OFF_ENA, 32'h40);
		apb(1'b1, cei_pkg::OFF_ICTL, 32'h40);
		chk("irq no global", 32'h0, 32'(irq));
		apb(1'b1, cei_pkg::OFF_ICTL, 32'hC0);
		chk("irq on", 32'h1, 32'(irq));
		apb(1'b1, cei_pkg::OFF_ENA, 32'h20);
		chk("irq other ch", 32'h0, 32'(irq));
		apb(1'b1, cei_pkg::OFF_ENA, 32'h40);
		repeat (20) @(posedge pclk);
		chk("irq sticky", 32'h1, 32'(irq));
		apb(1'b1, cei_pkg::OFF_FLAG, 32'h0);
		chk("irq cleared", 32'h0, 32'(irq));
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_modes();
		t_irq();
		stop_test();
	end
	// watchdog well beyond the roughly 760 cycles the tests need
	initial begin
		#300us;
		error_cnt++;
		stop_test();
	end
endmodule
